// *** hdl/aes_engine.sv ***
// AES-128 block cipher engine with AHB-Lite register slave
`timescale 1ns/100ps
`include "aes_engine_map.svh"

module aes_engine (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire aes_engine_pkg::word_t hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output aes_engine_pkg::word_t hrdata,
   output logic irq,
   output logic dma_trigger
);
   import aes_engine_pkg::*;

   // GF(2^8) multiply
   function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] p;
      logic [7:0] x;
      p = 8'h00;
      x = a;
      for (int i = 0; i < 8; i++) begin
         if (b[i]) p = p ^ x;
         x = {x[6:0], 1'b0} ^ (x[7] ? 8'h1b : 8'h00);
      end
      return p;
   endfunction : gmul

   // Multiplicative inverse as x^254, zero maps to zero
   function automatic logic [7:0] ginv(input logic [7:0] a);
      logic [7:0] r;
      logic [7:0] s;
      r = 8'h01;
      s = a;
      for (int i = 1; i < 8; i++) begin
         s = gmul(s, s);
         r = gmul(r, s);
      end
      return r;
   endfunction : ginv

   // Forward substitution; computed rather than tabled to save lines
   function automatic logic [7:0] sbox(input logic [7:0] a);
      logic [7:0] b;
      logic [7:0] o;
      b = ginv(a);
      for (int i = 0; i < 8; i++) begin
         o[i] = b[i] ^ b[(i + 4) % 8] ^ b[(i + 5) % 8] ^ b[(i + 6) % 8] ^ b[(i + 7) % 8];
      end
      return o ^ 8'h63;
   endfunction : sbox

   // Inverse substitution
   function automatic logic [7:0] inv_sbox(input logic [7:0] a);
      logic [7:0] o;
      for (int i = 0; i < 8; i++) begin
         o[i] = a[(i + 2) % 8] ^ a[(i + 5) % 8] ^ a[(i + 7) % 8];
      end
      return ginv(o ^ 8'h05);
   endfunction : inv_sbox

   function automatic logic [7:0] xtime(input logic [7:0] a);
      return {a[6:0], 1'b0} ^ (a[7] ? 8'h1b : 8'h00);
   endfunction : xtime

   // Undo one doubling of the round constant
   function automatic logic [7:0] xtime_inv(input logic [7:0] a);
      return a[0] ? (((a ^ 8'h1b) >> 1) | 8'h80) : (a >> 1);
   endfunction : xtime_inv

   function automatic word_t sub_rot(input word_t w, input logic [7:0] rc);
      return {sbox(w[23:16]) ^ rc, sbox(w[15:8]), sbox(w[7:0]), sbox(w[31:24])};
   endfunction : sub_rot

   // Next round key from current
   function automatic block_t key_fwd(input block_t k, input logic [7:0] rc);
      word_t w0;
      word_t w1;
      word_t w2;
      word_t w3;
      w0 = k[127:96] ^ sub_rot(k[31:0], rc);
      w1 = k[95:64] ^ w0;
      w2 = k[63:32] ^ w1;
      w3 = k[31:0] ^ w2;
      return {w0, w1, w2, w3};
   endfunction : key_fwd

   // Previous round key from current
   function automatic block_t key_back(input block_t k, input logic [7:0] rc);
      word_t w1;
      word_t w2;
      word_t w3;
      w3 = k[31:0] ^ k[63:32];
      w2 = k[63:32] ^ k[95:64];
      w1 = k[95:64] ^ k[127:96];
      return {k[127:96] ^ sub_rot(w3, rc), w1, w2, w3};
   endfunction : key_back

   // One encryption round; byte b sits at bits 127-8b, column b/4, row b%4
   function automatic block_t enc_round(input block_t s, input block_t k, input logic last);
      block_t t;
      block_t m;
      logic [7:0] a0;
      logic [7:0] a1;
      logic [7:0] a2;
      logic [7:0] a3;
      for (int b = 0; b < 16; b++) begin
         t[127-8*b -: 8] = sbox(s[127-8*(((b / 4 + b % 4) % 4) * 4 + b % 4) -: 8]);
      end
      m = t;
      if (!last) begin
         for (int c = 0; c < 4; c++) begin
            a0 = t[127-32*c -: 8];
            a1 = t[119-32*c -: 8];
            a2 = t[111-32*c -: 8];
            a3 = t[103-32*c -: 8];
            m[127-32*c -: 8] = xtime(a0) ^ xtime(a1) ^ a1 ^ a2 ^ a3;
            m[119-32*c -: 8] = a0 ^ xtime(a1) ^ xtime(a2) ^ a2 ^ a3;
            m[111-32*c -: 8] = a0 ^ a1 ^ xtime(a2) ^ xtime(a3) ^ a3;
            m[103-32*c -: 8] = xtime(a0) ^ a0 ^ a1 ^ a2 ^ xtime(a3);
         end
      end
      return m ^ k;
   endfunction : enc_round

   // One decryption round of the inverse cipher
   function automatic block_t dec_round(input block_t s, input block_t k, input logic last);
      block_t t;
      block_t m;
      logic [7:0] a0;
      logic [7:0] a1;
      logic [7:0] a2;
      logic [7:0] a3;
      for (int b = 0; b < 16; b++) begin
         t[127-8*b -: 8] = inv_sbox(s[127-8*(((b / 4 + 4 - b % 4) % 4) * 4 + b % 4) -: 8]);
      end
      t = t ^ k;
      m = t;
      if (!last) begin
         for (int c = 0; c < 4; c++) begin
            a0 = t[127-32*c -: 8];
            a1 = t[119-32*c -: 8];
            a2 = t[111-32*c -: 8];
            a3 = t[103-32*c -: 8];
            m[127-32*c -: 8] = gmul(a0, 8'h0e) ^ gmul(a1, 8'h0b) ^ gmul(a2, 8'h0d) ^ gmul(a3, 8'h09);
            m[119-32*c -: 8] = gmul(a0, 8'h09) ^ gmul(a1, 8'h0e) ^ gmul(a2, 8'h0b) ^ gmul(a3, 8'h0d);
            m[111-32*c -: 8] = gmul(a0, 8'h0d) ^ gmul(a1, 8'h09) ^ gmul(a2, 8'h0e) ^ gmul(a3, 8'h0b);
            m[103-32*c -: 8] = gmul(a0, 8'h0b) ^ gmul(a1, 8'h0d) ^ gmul(a2, 8'h09) ^ gmul(a3, 8'h0e);
         end
      end
      return m;
   endfunction : dec_round

   word_stream_if ws ();

   logic [4:0] ctrl_reg;
   block_t key_reg;
   block_t state_reg;
   block_t rk_reg;
   logic [7:0] rcon_reg;
   logic [3:0] round_reg;
   logic [15:0] cyc_reg;
   logic [1:0] load_ptr_reg;
   logic decrypt_reg;
   logic done_reg;
   eng_state_t eng_reg;
   logic dph_wr_reg;
   logic dph_fifo_reg;
   logic [7:0] dph_addr_reg;
   logic hreadyout_reg;
   logic hresp_reg;
   word_t hrdata_reg;
   logic irq_reg;
   logic dma_reg;
   logic addr_ok;
   logic ctrl_wr;
   logic start_req;
   logic last_word;
   logic busy;
   logic finish;
   logic dec_sel;
   logic irq_en_sel;

   word_fifo #(
      .WIDTH(32),
      .DEPTH(`AES_FIFO_DEPTH)
   ) u_fifo (
      .hclk(hclk),
      .hresetn(hresetn),
      .ws(ws)
   );

   // Bus decode and engine status terms
   assign addr_ok = hsel && htrans[1] && hready;
   assign ctrl_wr = dph_wr_reg && (dph_addr_reg == `AES_CTRL_OFS);
   assign busy = (eng_reg != ST_IDLE);
   assign finish = (eng_reg == ST_WAIT) && (cyc_reg == `AES_LATENCY_CYCLES - 16'd1);
   assign ws.in_valid = dph_fifo_reg;
   assign ws.in_data = hwdata;
   // State memory accepts words only while idle, so the FIFO backs up onto the bus
   assign ws.out_ready = !busy;
   assign last_word = ws.out_valid && !busy && (load_ptr_reg == 2'd3);
   // Writing start or loading the last word under auto start; dropped while busy
   assign start_req = !busy && ((ctrl_wr && hwdata[`AES_CTRL_START]) || (last_word && ctrl_reg[`AES_CTRL_AUTO]));
   // Mode bits written together with start apply to that very start, not the next one
   assign dec_sel = ctrl_wr ? hwdata[`AES_CTRL_DECRYPT] : ctrl_reg[`AES_CTRL_DECRYPT];
   assign irq_en_sel = ctrl_wr ? hwdata[`AES_CTRL_IRQ_EN] : ctrl_reg[`AES_CTRL_IRQ_EN];

   // Address phase capture; FIFO writes add a wait state until the word is accepted
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dph_wr_reg <= 1'b0;
         dph_fifo_reg <= 1'b0;
         dph_addr_reg <= 8'h00;
         hreadyout_reg <= 1'b1;
      end else if (dph_fifo_reg) begin
         if (ws.in_ready) begin
            dph_fifo_reg <= 1'b0;
            hreadyout_reg <= 1'b1;
         end
      end else begin
         dph_wr_reg <= addr_ok && hwrite;
         dph_addr_reg <= haddr;
         dph_fifo_reg <= addr_ok && hwrite && (haddr == `AES_STATE_IN_OFS);
         hreadyout_reg <= !(addr_ok && hwrite && (haddr == `AES_STATE_IN_OFS));
      end
   end

   // Read data registered at the address phase; unmapped reads give zero
   // Result words read zero while busy, so no half-processed block leaks out
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_reg <= 32'h0000_0000;
      end else if (addr_ok && !hwrite) begin
         if (haddr == `AES_CTRL_OFS) begin
            hrdata_reg <= {27'h000_0000, ctrl_reg};
         end else if (haddr == `AES_STATUS_OFS) begin
            hrdata_reg <= {30'h0000_0000, busy, done_reg};
         end else if ({haddr[7:4], 4'h0} == `AES_RESULT0_OFS && haddr[1:0] == 2'b00 && !busy) begin
            hrdata_reg <= state_reg[127-32*haddr[3:2] -: 32];
         end else begin
            hrdata_reg <= 32'h0000_0000;
         end
      end
   end

   // Always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hresp_reg <= 1'b0;
      end else begin
         hresp_reg <= 1'b0;
      end
   end

   // Control bits; start is a strobe and not stored
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg <= `AES_CTRL_RESET_VAL;
      end else if (ctrl_wr) begin
         ctrl_reg <= {hwdata[4:1], 1'b0};
      end
   end

   // Key memory, word writes; changing it while busy is ignored
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         key_reg <= '0;
      end else if (dph_wr_reg && !busy && {dph_addr_reg[7:4], 4'h0} == `AES_KEY0_OFS &&
            dph_addr_reg[1:0] == 2'b00) begin
         key_reg[127-32*dph_addr_reg[3:2] -: 32] <= hwdata;
      end
   end

   // Load pointer over the four state words, rewinds on start
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         load_ptr_reg <= 2'd0;
      end else if (start_req) begin
         load_ptr_reg <= 2'd0;
      end else if (ws.out_valid && !busy) begin
         load_ptr_reg <= load_ptr_reg + 2'd1;
      end
   end

   // Sequencer: key expansion for decrypt, ten rounds, then pad to the fixed latency
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         eng_reg <= ST_IDLE;
         round_reg <= 4'd0;
         cyc_reg <= 16'd0;
         decrypt_reg <= 1'b0;
         rk_reg <= '0;
         rcon_reg <= `AES_RCON_FIRST;
      end else begin
         cyc_reg <= cyc_reg + 16'd1;
         case (eng_reg)
            ST_IDLE: begin
               if (start_req) begin
                  decrypt_reg <= dec_sel;
                  eng_reg <= dec_sel ? ST_KEYX : ST_RUN;
                  cyc_reg <= 16'd0;
                  round_reg <= 4'd0;
                  rk_reg <= key_reg;
                  rcon_reg <= `AES_RCON_FIRST;
               end
            end
            ST_KEYX: begin
               // Walk forward to the last round key, holding the final constant
               rk_reg <= key_fwd(rk_reg, rcon_reg);
               round_reg <= round_reg + 4'd1;
               if (round_reg == `AES_ROUNDS - 4'd1) begin
                  round_reg <= 4'd0;
                  eng_reg <= ST_RUN;
               end else begin
                  rcon_reg <= xtime(rcon_reg);
               end
            end
            ST_RUN: begin
               round_reg <= round_reg + 4'd1;
               if (round_reg != 4'd0) begin
                  rk_reg <= decrypt_reg ? key_back(rk_reg, rcon_reg) : key_fwd(rk_reg, rcon_reg);
                  rcon_reg <= decrypt_reg ? xtime_inv(rcon_reg) : xtime(rcon_reg);
               end
               if (round_reg == `AES_ROUNDS) begin
                  eng_reg <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (finish) begin
                  eng_reg <= ST_IDLE;
               end
            end
            default: begin
               eng_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // State memory: loads (plain or XOR) while idle, rounds while running
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= '0;
      end else if (eng_reg == ST_RUN) begin
         if (round_reg == 4'd0) begin
            state_reg <= state_reg ^ rk_reg;
         end else if (decrypt_reg) begin
            state_reg <= dec_round(state_reg, key_back(rk_reg, rcon_reg), round_reg == `AES_ROUNDS);
         end else begin
            state_reg <= enc_round(state_reg, key_fwd(rk_reg, rcon_reg), round_reg == `AES_ROUNDS);
         end
      end else if (ws.out_valid && !busy) begin
         if (ctrl_reg[`AES_CTRL_XOR]) begin
            state_reg[127-32*load_ptr_reg -: 32] <= state_reg[127-32*load_ptr_reg -: 32] ^ ws.out_data;
         end else begin
            state_reg[127-32*load_ptr_reg -: 32] <= ws.out_data;
         end
      end
   end

   // Done flag; start cannot coincide with finish since starts need idle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         done_reg <= 1'b0;
      end else if (finish) begin
         done_reg <= 1'b1;
      end else if (start_req) begin
         done_reg <= 1'b0;
      end
   end

   // Interrupt level follows done, gated by enable
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= (done_reg || finish) && !start_req && irq_en_sel;
      end
   end

   // One-cycle DMA trigger on each completion
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dma_reg <= 1'b0;
      end else begin
         dma_reg <= finish;
      end
   end

   assign hreadyout = hreadyout_reg;
   assign hresp = hresp_reg;
   assign hrdata = hrdata_reg;
   assign irq = irq_reg;
   assign dma_trigger = dma_reg;

   // Unused transfer size: only whole words are supported
   logic unused_size;
   assign unused_size = ^hsize;
endmodule : aes_engine

// *** pkg/aes_engine_map.svh ***
// Register offsets, field positions, reset values and timing counts of the AES engine
`ifndef AES_ENGINE_MAP_SVH
`define AES_ENGINE_MAP_SVH

// Register byte offsets
`define AES_CTRL_OFS 8'h00
`define AES_STATUS_OFS 8'h04
`define AES_STATE_IN_OFS 8'h08
`define AES_KEY0_OFS 8'h10
`define AES_RESULT0_OFS 8'h20

// Control register fields
`define AES_CTRL_START 0
`define AES_CTRL_DECRYPT 1
`define AES_CTRL_XOR 2
`define AES_CTRL_AUTO 3
`define AES_CTRL_IRQ_EN 4
`define AES_CTRL_RESET_VAL 5'h00

// Status register fields
`define AES_STAT_DONE 0
`define AES_STAT_BUSY 1

// Timing and sizes
`define AES_LATENCY_CYCLES 16'd375
`define AES_ROUNDS 4'd10
`define AES_FIFO_DEPTH 8
`define AES_RCON_FIRST 8'h01
`define AES_RCON_LAST 8'h36

`endif

// *** pkg/aes_engine_pkg.sv ***
// Types shared by the AES engine modules
package aes_engine_pkg;
   typedef logic [31:0] word_t;
   typedef logic [127:0] block_t;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_KEYX = 4'b0010,
      ST_RUN = 4'b0100,
      ST_WAIT = 4'b1000
   } eng_state_t;
endpackage : aes_engine_pkg

// *** pkg/word_stream_if.sv ***
// Valid/ready word stream carrying data into and out of the input FIFO
`timescale 1ns/100ps
interface word_stream_if;
   logic in_valid;
   logic in_ready;
   logic [31:0] in_data;
   logic out_valid;
   logic out_ready;
   logic [31:0] out_data;
   modport fifo (input in_valid, output in_ready, input in_data, output out_valid, input out_ready,
      output out_data);
   modport user (output in_valid, input in_ready, output in_data, input out_valid, output out_ready,
      input out_data);
endinterface : word_stream_if

// *** hdl/word_fifo.sv ***
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module word_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   input wire logic hclk,
   input wire logic hresetn,
   word_stream_if.fifo ws
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr_reg;
   logic [AW:0] rd_ptr_reg;
   logic full;
   logic empty;

   // Extra pointer bit tells full from empty
   assign empty = (wr_ptr_reg == rd_ptr_reg);
   assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
   assign ws.in_ready = !full;
   assign ws.out_valid = !empty;
   assign ws.out_data = mem[rd_ptr_reg[AW-1:0]];

   // Storage, no reset needed for data
   always_ff @(posedge hclk) begin
      if (ws.in_valid && !full) begin
         mem[wr_ptr_reg[AW-1:0]] <= ws.in_data;
      end
   end

   // Write pointer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ptr_reg <= '0;
      end else if (ws.in_valid && !full) begin
         wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
   end

   // Read pointer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_ptr_reg <= '0;
      end else if (ws.out_ready && !empty) begin
         rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
   end
endmodule : word_fifo

// *** dv/aes_engine_props.sv ***
// Port-level checks of the AES engine bus and completion timing
`timescale 1ns/100ps
`include "aes_engine_map.svh"
module aes_engine_props (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire aes_engine_pkg::word_t hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire aes_engine_pkg::word_t hrdata,
   input wire logic irq,
   input wire logic dma_trigger
);
   import aes_engine_pkg::*;
   logic taken;
   logic ctrl_dph;
   logic pend;
   logic [15:0] cnt;
   assign taken = hsel && htrans[1] && hready;
   // Control write sitting in its data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) ctrl_dph <= 1'b0;
      else if (taken) ctrl_dph <= hwrite && (haddr == `AES_CTRL_OFS);
      else if (hready) ctrl_dph <= 1'b0;
   end
   // Cycles since an accepted start; later starts are ignored, so they do not restart it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend <= 1'b0;
         cnt <= 16'h0000;
      end else if (ctrl_dph && hready && hwdata[`AES_CTRL_START] && !pend) begin
         pend <= 1'b1;
         cnt <= 16'h0000;
      end else if (dma_trigger) pend <= 1'b0;
      else if (pend) cnt <= cnt + 16'h0001;
   end
   property p_latency; @(posedge hclk) disable iff (!hresetn)
      pend |-> (dma_trigger == (cnt == `AES_LATENCY_CYCLES)); endproperty
   a_latency: assert property (p_latency) else $error("completion not at the fixed latency");
   property p_pulse; @(posedge hclk) disable iff (!hresetn) dma_trigger |=> !dma_trigger; endproperty
   a_pulse: assert property (p_pulse) else $error("trigger longer than one cycle");
   property p_irq_rise; @(posedge hclk) disable iff (!hresetn) $rose(irq) |-> dma_trigger || $past(ctrl_dph); endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("irq rose without completion");
   property p_irq_fall; @(posedge hclk) disable iff (!hresetn) $fell(irq) |-> $past(ctrl_dph); endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq dropped on its own");
   property p_push_wait; @(posedge hclk) disable iff (!hresetn)
      taken && hwrite && (haddr == `AES_STATE_IN_OFS) |=> !hreadyout; endproperty
   a_push_wait: assert property (p_push_wait) else $error("state write without wait state");
   property p_push_bound; @(posedge hclk) disable iff (!hresetn) !hreadyout |-> ##[1:400] hreadyout; endproperty
   a_push_bound: assert property (p_push_bound) else $error("bus stalled too long");
   property p_rd_stable; @(posedge hclk) disable iff (!hresetn) !(taken && !hwrite) |=> $stable(hrdata); endproperty
   a_rd_stable: assert property (p_rd_stable) else $error("read data moved");
   property p_rd_ready; @(posedge hclk) disable iff (!hresetn)
      taken && !(hwrite && (haddr == `AES_STATE_IN_OFS)) |=> hreadyout && !hresp; endproperty
   a_rd_ready: assert property (p_rd_ready) else $error("register access delayed");
endmodule : aes_engine_props
bind aes_engine aes_engine_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
   .hresp(hresp), .hrdata(hrdata), .irq(irq), .dma_trigger(dma_trigger));

// *** dv/ahb_master.sv ***
// Bus master model standing for the processor that loads key and state
`timescale 1ns/100ps
module ahb_master (
   input wire logic hclk,
   input wire logic hready,
   input wire aes_engine_pkg::word_t hrdata,
   output logic hsel,
   output logic [7:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output aes_engine_pkg::word_t hwdata
);
   import aes_engine_pkg::*;
   // Idle bus at time zero
   initial begin
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
   end
   // Single word transfer; each phase is held until hready is sampled high
   task xfer(input logic wr, input logic [7:0] a, input word_t d, output word_t q);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      haddr <= ~a;
      hwdata <= wr ? d : ~d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
      // Released data must not keep showing the last word
      hwdata <= ~d;
   endtask : xfer
endmodule : ahb_master

// *** dv/testbench.sv ***
// Self-checking bench of the AES engine over its register bus
`timescale 1ns/100ps
`include "aes_engine_map.svh"
module testbench;
   import aes_engine_pkg::*;
   typedef struct {logic dec; logic ien; block_t din; block_t dout;} row_t;
   localparam block_t KEY = 128'h0001_0203_0405_0607_0809_0a0b_0c0d_0e0f;
   localparam block_t PLN = 128'h0011_2233_4455_6677_8899_aabb_ccdd_eeff;
   localparam block_t CIP = 128'h69c4_e0d8_6a7b_0430_d8cd_b780_70b4_c55a;
   logic hclk;
   logic hresetn;
   logic hsel;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   word_t hwdata;
   logic hready;
   logic hreadyout;
   logic hresp;
   word_t hrdata;
   logic irq;
   logic dma_trigger;
   word_t w;
   int fails = 0;
   int total_checks = 0;
   row_t rows [2] = '{'{1'b0, 1'b1, PLN, CIP}, '{1'b1, 1'b0, CIP, PLN}};
   assign hready = hreadyout;
   aes_engine dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .irq(irq), .dma_trigger(dma_trigger));
   ahb_master bm (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   task chk(input word_t got, input word_t exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task wr(input logic [7:0] a, input word_t d);
      word_t q;
      bm.xfer(1'b1, a, d, q);
   endtask : wr
   task rd(input logic [7:0] a, output word_t q);
      bm.xfer(1'b0, a, 32'h0000_0000, q);
   endtask : rd
   // Key words go to successive offsets, state words all through one port
   task load(input block_t b, input logic [7:0] base, input logic step);
      for (int i = 0; i < 4; i++) wr(base + (step ? 8'(4 * i) : 8'h00), b[127 - 32 * i -: 32]);
   endtask : load
   task rd_blk(input block_t exp);
      for (int i = 0; i < 4; i++) begin
         rd(`AES_RESULT0_OFS + 8'(4 * i), w);
         chk(w, exp[127 - 32 * i -: 32]);
      end
   endtask : rd_blk
   // Pulse rises with done and is seen here one edge later
   task wait_dma(input time t0, input logic ien, input logic timed);
      int k;
      k = 0;
      do begin
         @(posedge hclk);
         k++;
      end while (dma_trigger !== 1'b1 && k < 2000);
      chk({31'h0, dma_trigger}, 32'h0000_0001);
      if (timed) chk(word_t'(($time - t0) / 20), word_t'(`AES_LATENCY_CYCLES) + 32'h0000_0001);
      chk({31'h0, irq}, {31'h0, ien});
   endtask : wait_dma
   task finish_test;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test
   // Free-running clock
   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end
   // Run far longer than the tests need
   initial begin
      repeat (20000) @(posedge hclk);
      fails++;
      $display("Error at %0t: watchdog expired", $time);
      finish_test;
   end
   initial begin
      time t0;
      hresetn = 1'b0;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (rows[r]) begin
         load(KEY, `AES_KEY0_OFS, 1'b1);
         load(rows[r].din, `AES_STATE_IN_OFS, 1'b0);
         w = {27'h0, rows[r].ien, 2'h0, rows[r].dec, 1'b1};
         wr(`AES_CTRL_OFS, w);
         t0 = $time;
         rd(`AES_STATUS_OFS, w);
         chk(w, 32'h0000_0002);
         rd(`AES_RESULT0_OFS, w);
         chk(w, 32'h0000_0000);
         wr(`AES_CTRL_OFS, {27'h0, rows[r].ien, 2'h0, ~rows[r].dec, 1'b1});
         wait_dma(t0, rows[r].ien, 1'b1);
         rd(`AES_STATUS_OFS, w);
         chk(w, 32'h0000_0001);
         rd_blk(rows[r].dout);
         $display("test row %0d done", r);
      end
      // Chaining load folds new words into the held block
      wr(`AES_CTRL_OFS, 32'h0000_0004);
      load(KEY, `AES_STATE_IN_OFS, 1'b0);
      rd_blk(PLN ^ KEY);
      $display("test xor load done");
      wr(`AES_CTRL_OFS, 32'h0000_0008);
      load(PLN, `AES_STATE_IN_OFS, 1'b0);
      wait_dma(0, 1'b0, 1'b0);
      rd_blk(CIP);
      $display("test auto start done");
      // Nine pushes while busy: the ninth must wait for completion
      wr(`AES_CTRL_OFS, 32'h0000_0001);
      for (int i = 0; i < 9; i++) wr(`AES_STATE_IN_OFS, {4{8'(i)}});
      rd(`AES_STATUS_OFS, w);
      chk(w, 32'h0000_0001);
      repeat (16) @(posedge hclk);
      rd_blk({32'h0808_0808, 32'h0505_0505, 32'h0606_0606, 32'h0707_0707});
      rd(`AES_KEY0_OFS, w);
      chk(w, 32'h0000_0000);
      rd(8'h40, w);
      chk(w, 32'h0000_0000);
      $display("test fifo full done");
      hresetn <= 1'b0;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      rd(`AES_CTRL_OFS, w);
      chk(w, 32'h0000_0000);
      rd(`AES_STATUS_OFS, w);
      chk(w, 32'h0000_0000);
      rd(`AES_RESULT0_OFS, w);
      chk(w, 32'h0000_0000);
      $display("test second reset done");
      finish_test;
   end
endmodule : testbench
